// ---- modbus_rtu_params.svh ----
// Purpose: Constants for the Modbus RTU register slave
// Assumes: 10 MHz system clock
// Notes: Included by the slave; definitions only
// Functional notes
// - Character format 8N2 default, 8N1, 8E1, 8O1
// - Five baud rates, 38400 after default
// - Register n sits at protocol address n-1
// - Function 4 reads same space as 3
// - Functions 3 and 6 always supported
// - Functions 2, 4, 16 also supported
// - Discrete bits map register 104 times 16
// - Registers carry unsigned 16-bit raw values
// - 32-bit values: low word at lower address
// - Unsupported register reads back as 65535
`ifndef MODBUS_RTU_PARAMS_SVH
`define MODBUS_RTU_PARAMS_SVH

`define CLK_HZ 10000000
`define BAUD_DIV(b) (((`CLK_HZ) + (b) / 2) / (b))
`define BAUD_9600 9600
`define BAUD_19200 19200
`define BAUD_38400 38400
`define BAUD_76800 76800
`define BAUD_115200 115200
// Silent line of 3.5 characters of 11 bits, rounded up
`define GAP_BITS 6'd39
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001
`define FC_RD_BITS 8'h02
`define FC_RD_HOLD 8'h03
`define FC_RD_INPUT 8'h04
`define FC_WR_ONE 8'h06
`define FC_WR_MANY 8'h10
`define EXC_FLAG 8'h80
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define MALF_ADDR 16'h0068
`define MALF_BIT0 17'h00680
`define MALF_BIT_END 17'h00690
`define BITS_MAX_QTY 16'h0010
`define RD_MAX_QTY 16'h007d
`define WR_MAX_QTY 16'h007b
`define STATION_MAX 8'hf7
`define STATION_DFLT 8'h01
`define UNSUP_VALUE 16'hffff
`define MIN_LEN 9'h004
`define FIX_LEN 9'h008
`define WR_MANY_HDR 9'h009
`define BUF_FULL 9'h100
`define WR_DATA_POS 8'h07
`define RD_HDR_LEN 9'h003
`define ECHO_LEN 9'h006
`define BITS_8N2 4'd11
`define BITS_8N1 4'd10

`endif

// ---- modbus_rtu_pkg.sv ----
// Purpose: Types for the Modbus RTU register slave
// Assumes: Nothing beyond the params header
// Notes: Enum codes of baud and format pick defaults at zero
package modbus_rtu_pkg;

  typedef enum logic [1:0] {
    FMT_8N2 = 2'h0,
    FMT_8N1 = 2'h1,
    FMT_8E1 = 2'h2,
    FMT_8O1 = 2'h3
  } char_fmt_t;

  typedef enum logic [2:0] {
    BAUD_38400 = 3'h0,
    BAUD_9600 = 3'h1,
    BAUD_19200 = 3'h2,
    BAUD_76800 = 3'h3,
    BAUD_115200 = 3'h4
  } baud_sel_t;

  typedef enum logic [5:0] {
    ST_RECV = 6'h01,
    ST_DECODE = 6'h02,
    ST_RDREQ = 6'h04,
    ST_RDDATA = 6'h08,
    ST_WRITE = 6'h10,
    ST_SEND = 6'h20
  } slave_state_t;

  typedef struct packed {
    char_fmt_t fmt;
    baud_sel_t baud;
    logic [7:0] station;
  } link_cfg_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ok;
    logic [15:0] data;
  } reg_rsp_t;

endpackage

// ---- modbus_rtu_register_slave.sv ----
// Purpose: Modbus RTU slave: UART, framing, decode, register access
// Assumes: Inputs synchronous to i_clk_sys; register answer in the same cycle as rd
// Notes: Half duplex; bytes arriving while answering are dropped
`timescale 1ns/100ps
`default_nettype none
`include "modbus_rtu_params.svh"

module modbus_rtu_register_slave (
  input wire logic i_clk_sys, // System clock, 10 MHz
  input wire logic i_srst, // Synchronous reset, active high
  input wire modbus_rtu_pkg::link_cfg_t i_cfg, // Format, baud, station
  input wire logic i_rx, // RS-485 receive data
  output logic o_tx, // RS-485 transmit data
  output logic o_tx_en, // RS-485 driver enable
  output modbus_rtu_pkg::reg_req_t o_reg_req, // Register read/write request
  input wire modbus_rtu_pkg::reg_rsp_t i_reg_rsp // Read data and support flag
);

  modbus_rtu_pkg::link_cfg_t cfg_r;
  modbus_rtu_pkg::slave_state_t state_r;
  logic [10:0] div;
  logic has_par;
  logic odd_par;

  logic rx_busy_r, rx_stb_r, rx_bad_r, rx_acc_r;
  logic [3:0] rx_bit_r;
  logic [10:0] rx_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rxbuf [0:255];
  logic [8:0] rx_len_r;
  logic [15:0] rx_crc_r;
  logic rx_err_r;
  logic [10:0] gap_div_r;
  logic [5:0] gap_cnt_r;
  logic frame_end;

  logic [7:0] txbuf [0:255];
  logic [8:0] tlen_r, txi_r;
  logic [15:0] tx_crc_r;
  logic [15:0] cur_addr_r, idx_r;
  logic [7:0] rp_r;
  logic tx_busy_r;
  logic [10:0] tx_cnt_r, tx_sh_r;
  logic [3:0] tx_left_r;
  logic tx_go;
  logic [7:0] tx_byte;
  logic [10:0] tx_frame;

  logic [7:0] fc;
  logic [15:0] p_addr, p_qty, rdata, bit_off, bits;
  logic [16:0] bit_end;
  logic frame_ok;

  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Config only changes between frames, so a frame never sees two rates
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cfg_r <= '{modbus_rtu_pkg::FMT_8N2, modbus_rtu_pkg::BAUD_38400, `STATION_DFLT};
    end else if (state_r == modbus_rtu_pkg::ST_RECV && rx_len_r == 9'h000 && !rx_busy_r) begin
      cfg_r.fmt <= i_cfg.fmt;
      cfg_r.baud <= i_cfg.baud;
      if (i_cfg.station == 8'h00 || i_cfg.station > `STATION_MAX) begin
        cfg_r.station <= `STATION_DFLT;
      end else begin
        cfg_r.station <= i_cfg.station;
      end
    end
  end

  always_comb begin
    case (cfg_r.baud)
      modbus_rtu_pkg::BAUD_9600: div = 11'(`BAUD_DIV(`BAUD_9600));
      modbus_rtu_pkg::BAUD_19200: div = 11'(`BAUD_DIV(`BAUD_19200));
      modbus_rtu_pkg::BAUD_76800: div = 11'(`BAUD_DIV(`BAUD_76800));
      modbus_rtu_pkg::BAUD_115200: div = 11'(`BAUD_DIV(`BAUD_115200));
      default: div = 11'(`BAUD_DIV(`BAUD_38400));
    endcase
    has_par = cfg_r.fmt == modbus_rtu_pkg::FMT_8E1 || cfg_r.fmt == modbus_rtu_pkg::FMT_8O1;
    odd_par = cfg_r.fmt == modbus_rtu_pkg::FMT_8O1;
  end

  // Receiver: samples mid-bit, checks parity and one stop bit
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_busy_r <= 1'b0;
      rx_stb_r <= 1'b0;
      rx_bad_r <= 1'b0;
      rx_acc_r <= 1'b0;
      rx_bit_r <= 4'h0;
      rx_cnt_r <= 11'h000;
      rx_sh_r <= 8'h00;
    end else begin
      rx_stb_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!i_rx) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= div >> 1;
          rx_bit_r <= 4'h0;
          rx_acc_r <= 1'b0;
        end
      end else if (rx_cnt_r != 11'h000) begin
        rx_cnt_r <= rx_cnt_r - 11'h001;
      end else begin
        rx_cnt_r <= div - 11'h001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0) begin
          if (i_rx) begin
            rx_busy_r <= 1'b0;
          end
        end else if (rx_bit_r <= 4'h8) begin
          rx_sh_r <= {i_rx, rx_sh_r[7:1]};
          rx_acc_r <= rx_acc_r ^ i_rx;
        end else if (rx_bit_r == 4'h9 && has_par) begin
          rx_acc_r <= rx_acc_r ^ i_rx;
        end else begin
          rx_busy_r <= 1'b0;
          rx_stb_r <= 1'b1;
          rx_bad_r <= !i_rx || (has_par && rx_acc_r != odd_par);
        end
      end
    end
  end

  // Frame store with running CRC; a good frame leaves a zero residue
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || state_r != modbus_rtu_pkg::ST_RECV) begin
      rx_len_r <= 9'h000;
      rx_crc_r <= `CRC_INIT;
      rx_err_r <= 1'b0;
    end else if (rx_stb_r) begin
      if (rx_len_r != `BUF_FULL) begin
        rxbuf[rx_len_r[7:0]] <= rx_sh_r;
        rx_len_r <= rx_len_r + 9'h001;
      end
      rx_crc_r <= crc16(rx_crc_r, rx_sh_r);
      rx_err_r <= rx_err_r || rx_bad_r || rx_len_r == `BUF_FULL;
    end
  end

  // Idle line timer counted in bit times, so it scales with the rate
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || rx_busy_r || !i_rx) begin
      gap_div_r <= 11'h000;
      gap_cnt_r <= 6'h00;
    end else if (gap_cnt_r != `GAP_BITS) begin
      if (gap_div_r == div - 11'h001) begin
        gap_div_r <= 11'h000;
        gap_cnt_r <= gap_cnt_r + 6'h01;
      end else begin
        gap_div_r <= gap_div_r + 11'h001;
      end
    end
  end

  assign frame_end = state_r == modbus_rtu_pkg::ST_RECV && gap_cnt_r == `GAP_BITS && rx_len_r != 9'h000;

  always_comb begin
    fc = rxbuf[1];
    p_addr = {rxbuf[2], rxbuf[3]};
    p_qty = {rxbuf[4], rxbuf[5]};
    frame_ok = !rx_err_r && rx_crc_r == 16'h0000 && rx_len_r >= `MIN_LEN && rxbuf[0] == cfg_r.station;
    rdata = i_reg_rsp.ok ? i_reg_rsp.data : `UNSUP_VALUE;
    bit_off = 16'({1'b0, p_addr} - `MALF_BIT0);
    bit_end = {1'b0, p_addr} + {1'b0, p_qty};
    bits = (rdata >> bit_off[3:0]) & 16'((17'h00001 << p_qty[4:0]) - 17'h00001);
  end

  // Request handling and answer assembly
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_r <= modbus_rtu_pkg::ST_RECV;
      o_reg_req <= '0;
      tlen_r <= 9'h000;
      txi_r <= 9'h000;
      tx_crc_r <= `CRC_INIT;
      cur_addr_r <= 16'h0000;
      idx_r <= 16'h0000;
      rp_r <= 8'h00;
    end else begin
      o_reg_req.rd <= 1'b0;
      o_reg_req.wr <= 1'b0;
      case (state_r)
        modbus_rtu_pkg::ST_RECV: begin
          txi_r <= 9'h000;
          tx_crc_r <= `CRC_INIT;
          if (frame_end) begin
            state_r <= modbus_rtu_pkg::ST_DECODE;
          end
        end
        modbus_rtu_pkg::ST_DECODE: begin
          txbuf[0] <= cfg_r.station;
          txbuf[1] <= fc | `EXC_FLAG;
          txbuf[2] <= `EXC_VALUE;
          tlen_r <= `RD_HDR_LEN;
          state_r <= modbus_rtu_pkg::ST_SEND;
          cur_addr_r <= p_addr;
          idx_r <= p_qty;
          rp_r <= `WR_DATA_POS;
          if (!frame_ok) begin
            state_r <= modbus_rtu_pkg::ST_RECV;
          end else begin
            case (fc)
              `FC_RD_HOLD, `FC_RD_INPUT: begin
                if (p_qty != 16'h0000 && p_qty <= `RD_MAX_QTY && rx_len_r == `FIX_LEN) begin
                  txbuf[1] <= fc;
                  txbuf[2] <= {p_qty[6:0], 1'b0};
                  state_r <= modbus_rtu_pkg::ST_RDREQ;
                end
              end
              `FC_WR_ONE: begin
                if (rx_len_r == `FIX_LEN) begin
                  txbuf[1] <= fc;
                  for (int i = 2; i < 6; i++) begin
                    txbuf[i] <= rxbuf[i];
                  end
                  tlen_r <= `ECHO_LEN;
                  o_reg_req <= '{1'b0, 1'b1, p_addr, p_qty};
                end
              end
              `FC_WR_MANY: begin
                if (p_qty != 16'h0000 && p_qty <= `WR_MAX_QTY && rxbuf[6] == {p_qty[6:0], 1'b0}
                    && rx_len_r == 9'(`WR_MANY_HDR + {p_qty[7:0], 1'b0})) begin
                  txbuf[1] <= fc;
                  for (int i = 2; i < 6; i++) begin
                    txbuf[i] <= rxbuf[i];
                  end
                  tlen_r <= `ECHO_LEN;
                  state_r <= modbus_rtu_pkg::ST_WRITE;
                end
              end
              `FC_RD_BITS: begin
                if (p_qty != 16'h0000 && p_qty <= `BITS_MAX_QTY && {1'b0, p_addr} >= `MALF_BIT0
                    && bit_end <= `MALF_BIT_END) begin
                  txbuf[1] <= fc;
                  cur_addr_r <= `MALF_ADDR;
                  state_r <= modbus_rtu_pkg::ST_RDREQ;
                end else begin
                  txbuf[2] <= `EXC_ADDR;
                end
              end
              default: begin
                txbuf[2] <= `EXC_FUNC;
              end
            endcase
          end
        end
        modbus_rtu_pkg::ST_RDREQ: begin
          o_reg_req.rd <= 1'b1;
          o_reg_req.addr <= cur_addr_r;
          state_r <= modbus_rtu_pkg::ST_RDDATA;
        end
        modbus_rtu_pkg::ST_RDDATA: begin
          if (fc == `FC_RD_BITS) begin
            txbuf[2] <= (p_qty > 16'h0008) ? 8'h02 : 8'h01;
            txbuf[3] <= bits[7:0];
            txbuf[4] <= bits[15:8];
            tlen_r <= (p_qty > 16'h0008) ? 9'h005 : 9'h004;
            state_r <= modbus_rtu_pkg::ST_SEND;
          end else begin
            // Big-endian bytes within each register, words in address order
            txbuf[tlen_r[7:0]] <= rdata[15:8];
            txbuf[8'(tlen_r[7:0] + 8'h01)] <= rdata[7:0];
            tlen_r <= tlen_r + 9'h002;
            cur_addr_r <= cur_addr_r + 16'h0001;
            idx_r <= idx_r - 16'h0001;
            state_r <= (idx_r == 16'h0001) ? modbus_rtu_pkg::ST_SEND : modbus_rtu_pkg::ST_RDREQ;
          end
        end
        modbus_rtu_pkg::ST_WRITE: begin
          // One write per cycle; a 32-bit pair lands low word first
          o_reg_req <= '{1'b0, 1'b1, cur_addr_r, {rxbuf[rp_r], rxbuf[8'(rp_r + 8'h01)]}};
          rp_r <= rp_r + 8'h02;
          cur_addr_r <= cur_addr_r + 16'h0001;
          idx_r <= idx_r - 16'h0001;
          if (idx_r == 16'h0001) begin
            state_r <= modbus_rtu_pkg::ST_SEND;
          end
        end
        modbus_rtu_pkg::ST_SEND: begin
          if (tx_go) begin
            txi_r <= txi_r + 9'h001;
            if (txi_r < tlen_r) begin
              tx_crc_r <= crc16(tx_crc_r, tx_byte);
            end
          end else if (!tx_busy_r && txi_r == tlen_r + 9'h002) begin
            state_r <= modbus_rtu_pkg::ST_RECV;
          end
        end
        default: begin
          state_r <= modbus_rtu_pkg::ST_RECV;
        end
      endcase
    end
  end

  always_comb begin
    tx_go = state_r == modbus_rtu_pkg::ST_SEND && !tx_busy_r && txi_r < tlen_r + 9'h002;
    if (txi_r < tlen_r) begin
      tx_byte = txbuf[txi_r[7:0]];
    end else if (txi_r == tlen_r) begin
      tx_byte = tx_crc_r[7:0];
    end else begin
      tx_byte = tx_crc_r[15:8];
    end
    if (has_par) begin
      tx_frame = {1'b1, ^tx_byte ^ odd_par, tx_byte, 1'b0};
    end else begin
      tx_frame = {2'b11, tx_byte, 1'b0};
    end
  end

  // Transmitter; 8N1 simply stops after the first stop bit
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_tx <= 1'b1;
      o_tx_en <= 1'b0;
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 11'h000;
      tx_sh_r <= 11'h7ff;
      tx_left_r <= 4'h0;
    end else begin
      o_tx_en <= state_r == modbus_rtu_pkg::ST_SEND;
      if (tx_go) begin
        tx_busy_r <= 1'b1;
        o_tx <= tx_frame[0];
        tx_sh_r <= tx_frame >> 1;
        tx_left_r <= (cfg_r.fmt == modbus_rtu_pkg::FMT_8N1) ? `BITS_8N1 - 4'h1 : `BITS_8N2 - 4'h1;
        tx_cnt_r <= div - 11'h001;
      end else if (tx_busy_r) begin
        if (tx_cnt_r != 11'h000) begin
          tx_cnt_r <= tx_cnt_r - 11'h001;
        end else if (tx_left_r == 4'h0) begin
          tx_busy_r <= 1'b0;
          o_tx <= 1'b1;
        end else begin
          o_tx <= tx_sh_r[0];
          tx_sh_r <= {1'b1, tx_sh_r[10:1]};
          tx_left_r <= tx_left_r - 4'h1;
          tx_cnt_r <= div - 11'h001;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- modbus_rtu_register_slave_asserts.sv ----
// Purpose: Port checker for the RTU slave
// Assumes: One clock domain, reset synchronous
// Notes: Bound to every slave instance
`timescale 1ns/100ps
`default_nettype none
module modbus_rtu_register_slave_asserts (
  input wire logic i_clk_sys, // Clock
  input wire logic i_srst, // Reset
  input wire logic o_tx, // Line out
  input wire logic o_tx_en, // Driver enable
  input wire modbus_rtu_pkg::reg_req_t o_reg_req // Register request
);
  logic last_r;
  logic [10:0] run_r;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Saturates so long idle spells never wrap
  always_ff @(posedge i_clk_sys) begin
    last_r <= o_tx;
    if (i_srst || (o_tx == last_r && run_r == 11'h7ff)) begin
      run_r <= 11'h7ff;
    end else if (o_tx != last_r) begin
      run_r <= 11'h001;
    end else begin
      run_r <= run_r + 11'h001;
    end
  end
  property p_idle_high; !o_tx_en |-> o_tx; endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while driver off");
  property p_bit_len; o_tx != last_r && o_tx_en && $past(o_tx_en) |-> run_r >= 11'h055; endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit shorter than fastest rate");
  property p_start_bit; $rose(o_tx_en) |-> ##[0:2] !o_tx; endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit after enable");
  property p_rd_pulse; o_reg_req.rd |=> !o_reg_req.rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe longer than a cycle");
  property p_one_kind; o_reg_req.rd |-> !o_reg_req.wr; endproperty
  a_one_kind: assert property (p_one_kind) else $error("read and write together");
  property p_rd_quiet; o_reg_req.rd |-> !o_tx_en; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read while answering");
  property p_wr_seq; o_reg_req.wr && $past(o_reg_req.wr) |-> o_reg_req.addr == $past(o_reg_req.addr) + 16'h0001;
  endproperty
  a_wr_seq: assert property (p_wr_seq) else $error("burst write address not consecutive");
  property p_addr_hold; !o_reg_req.rd && !o_reg_req.wr |-> $stable(o_reg_req.addr) && $stable(o_reg_req.wdata);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("request fields moved while idle");
endmodule
bind modbus_rtu_register_slave modbus_rtu_register_slave_asserts u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
  .o_tx(o_tx), .o_tx_en(o_tx_en), .o_reg_req(o_reg_req));
`default_nettype wire

// ---- modbus_master_model.sv ----
// Purpose: Bus master on the RS-485 side of the slave
// Assumes: 8N1 framing at one fixed bit time
// Notes: Line idles high as a biased bus does
`timescale 1ns/100ps
`default_nettype none
module modbus_master_model #(
  parameter int BIT = 87
) (
  input wire logic i_clk_sys, // Clock
  input wire logic i_tx, // Slave line out
  output logic o_rx // Line into slave
);
  initial o_rx = 1'b1;
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
    end
    return c;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic send(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      o_rx = 1'b0;
      tick(BIT);
      for (int k = 0; k < 8; k++) begin
        o_rx = q[i][k];
        tick(BIT);
      end
      o_rx = 1'b1;
      tick(BIT);
    end
  endtask
  // Samples mid-bit; ok drops on a missing byte, bad stop bit or bad CRC
  task automatic recv(input int n, input int wait_max, output logic [7:0] q[$], output logic ok);
    int t;
    logic [7:0] b;
    q = {};
    ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      t = 0;
      while (i_tx && t < wait_max) begin
        tick(1);
        t++;
      end
      if (i_tx) begin
        ok = 1'b0;
        return;
      end
      tick(BIT / 2);
      for (int k = 0; k < 8; k++) begin
        tick(BIT);
        b[k] = i_tx;
      end
      tick(BIT);
      ok = ok & i_tx;
      q.push_back(b);
    end
    if (crc16(q) != 16'h0000) ok = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- modbus_rtu_register_slave_test.sv ----
// Purpose: Self-checking bench for the RTU slave
// Assumes: 115200 baud 8N1, station 1
// Notes: Application side answers on the falling edge
`timescale 1ns/100ps
`default_nettype none
module modbus_rtu_register_slave_test;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic i_rx;
  logic o_tx;
  logic o_tx_en;
  modbus_rtu_pkg::link_cfg_t i_cfg = '{fmt: modbus_rtu_pkg::FMT_8N1, baud: modbus_rtu_pkg::BAUD_115200,
    station: 8'h01};
  modbus_rtu_pkg::reg_req_t o_reg_req;
  modbus_rtu_pkg::reg_rsp_t i_reg_rsp = '0;
  logic [15:0] mem [0:7];
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  always #50 i_clk_sys = ~i_clk_sys;
  modbus_rtu_register_slave dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_cfg(i_cfg), .i_rx(i_rx),
    .o_tx(o_tx), .o_tx_en(o_tx_en), .o_reg_req(o_reg_req), .i_reg_rsp(i_reg_rsp));
  modbus_master_model #(.BIT(87)) master (.i_clk_sys(i_clk_sys), .i_tx(o_tx), .o_rx(i_rx));
  // Unsupported slots hold 1234 so the all-ones answer must come from the slave
  always @(negedge i_clk_sys) begin
    i_reg_rsp.ok <= o_reg_req.addr < 16'h0005 || o_reg_req.addr == 16'h0068;
    i_reg_rsp.data <= (o_reg_req.addr == 16'h0068) ? 16'ha5c3 : mem[o_reg_req.addr[2:0]];
    if (o_reg_req.wr) mem[o_reg_req.addr[2:0]] <= o_reg_req.wdata;
  end
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 110000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (exp !== got) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic [7:0] req[$], input logic [7:0] exp[$]);
    logic [7:0] got[$];
    logic ok;
    master.send(req);
    master.recv(exp.size() + 2, 8000, got, ok);
    chk("answer frame", 16'h0001, {15'h0000, ok});
    foreach (exp[i]) chk("answer byte", {8'h00, exp[i]}, {8'h00, got[i]});
    master.tick(200);
  endtask
  task automatic t_read(input logic [7:0] fc);
    xfer('{8'h01, fc, 8'h00, 8'h04, 8'h00, 8'h02}, '{8'h01, fc, 8'h04, 8'h1a, 8'hc8, 8'hff, 8'hff});
  endtask
  task automatic t_write_one();
    xfer('{8'h01, 8'h06, 8'h00, 8'h00, 8'h01, 8'h02}, '{8'h01, 8'h06, 8'h00, 8'h00, 8'h01, 8'h02});
    chk("register 1", 16'h0102, mem[0]);
  endtask
  task automatic t_pair();
    xfer('{8'h01, 8'h10, 8'h00, 8'h02, 8'h00, 8'h02, 8'h04, 8'h38, 8'hd7, 8'h00, 8'h13},
      '{8'h01, 8'h10, 8'h00, 8'h02, 8'h00, 8'h02});
    chk("pair low", 16'(32'd1259735), mem[2]);
    chk("pair high", 16'(32'd1259735 >> 16), mem[3]);
  endtask
  task automatic t_bits();
    xfer('{8'h01, 8'h02, 8'h06, 8'h80, 8'h00, 8'h10}, '{8'h01, 8'h02, 8'h02, 8'hc3, 8'ha5});
  endtask
  task automatic t_other_station();
    logic [7:0] got[$];
    logic ok;
    master.send('{8'h02, 8'h03, 8'h00, 8'h04, 8'h00, 8'h01});
    master.recv(1, 4000, got, ok);
    chk("silent", 16'h0000, {15'h0000, ok});
  endtask
  initial begin
    for (int i = 0; i < 8; i++) begin
      mem[i] = 16'h1234;
    end
    mem[4] = 16'h1ac8;
    repeat (3) @(negedge i_clk_sys);
    i_srst = 1'b0;
    // Let the slave take the new rate before the first start bit
    repeat (2) @(negedge i_clk_sys);
    t_read(8'h03);
    t_read(8'h04);
    t_write_one();
    t_pair();
    t_bits();
    t_other_station();
    print_verdict();
  end
endmodule
`default_nettype wire
